//--- rtl/rcr_pkg.sv
// shared constants for the rtc control register block
package rcr_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_CAPTURE = 8'h08;
   localparam logic [7:0] ADDR_ALARM   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_MASK    = 8'h14;

   // control field positions
   localparam int BIT_OSC_EN    = 7;
   localparam int BIT_MCD_EN    = 6;
   localparam int BIT_OSC_FAIL  = 5;
   localparam int BIT_RUN       = 4;
   localparam int BIT_ALARM_EN  = 3;
   localparam int BIT_ALARM_AR  = 2;
   localparam int BIT_SET_GO    = 1;
   localparam int BIT_CAP_GO    = 0;

   // interrupt status / mask positions
   localparam int IRQ_OSC_FAIL  = 0;
   localparam int IRQ_ALARM     = 1;
   localparam int IRQ_W         = 2;

   // reset values and timer step
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [31:0] TIMER_ONE = 32'h0000_0001;

   // missing-clock timeout: at least 100 us at 5 ns per cycle
   localparam int MCD_TIMEOUT_NS = 100000;
   localparam int PCLK_PERIOD_NS = 5;
   localparam int MCD_CYCLES =
      (MCD_TIMEOUT_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
endpackage : rcr_pkg

//--- rtl/rcr_clock_watch.sv
// oscillator pin synchroniser, tick and missing-clock timer
`timescale 1ns/1ps
module rcr_clock_watch
   import rcr_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int LIMIT = MCD_CYCLES
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // oscillator pin
   input  wire logic osc_in,
   // control
   input  wire logic detect_en,
   // events
   output logic      tick,
   output logic      timeout
);
   logic             s1_reg, s2_reg, s3_reg;
   logic             lvl_reg, lvl_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic             rise;
   logic             change;

   localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(LIMIT);
   localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

   always_comb begin
      // a level counts only once the second and third stage agree
      change   = (s2_reg == s3_reg) && (s3_reg != lvl_reg);
      rise     = change && s3_reg;
      lvl_next = change ? s3_reg : lvl_reg;
      cnt_next = cnt_reg;
      if (change || !detect_en) begin
         cnt_next = CNT_ZERO;
      end else if (cnt_reg != CNT_LIMIT) begin
         cnt_next = cnt_reg + CNT_ONE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         s3_reg  <= 1'b0;
         lvl_reg <= 1'b0;
         cnt_reg <= CNT_ZERO;
      end else begin
         s1_reg  <= osc_in;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         lvl_reg <= lvl_next;
         cnt_reg <= cnt_next;
      end
   end

   assign tick = rise;
   // one-shot: fires once as the count reaches the limit
   assign timeout = detect_en && !change
                    && (cnt_reg == CNT_LIMIT - CNT_ONE);
endmodule : rcr_clock_watch

//--- rtl/rcr_control.sv
// rtc control register, timer, alarm and apb slave
`timescale 1ns/1ps
// Behaviour
// - bit 7 powers oscillator and bias
// - bit 6 enables missing-clock detector
// - detector timeout sets oscillator-fail bit 5
// - fail flag sticks until software clears
// - bit 4 runs timer, else holds count
// - bit 3 enables alarm events
// - writing alarm-enable 0 clears alarm flag, but a match tick in the same cycle sets it
// - bit 2 reads alarm event flag
// - bit 2 write sets auto-reset enable
// - control register sits at address 0x04
// - set bit copies capture into timer
// - capture bit snapshots timer into capture
// - detector times out after 100 us still
// - auto-reset zeroes timer after alarm ends
module rcr_control
   import rcr_pkg::*;
#(
   parameter int TIMER_W = 32,
   parameter int MCD_LIMIT = MCD_CYCLES
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // oscillator
   input  wire logic        osc_in,
   output logic             osc_enable,
   // events
   output logic             alarm_event,
   output logic             irq
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a[7:2] == o[7:2]);
   endfunction : hit

   // control bits
   logic               osc_en_reg,     osc_en_next;
   logic               mcd_en_reg,     mcd_en_next;
   logic               fail_reg,       fail_next;
   logic               run_reg,        run_next;
   logic               alarm_en_reg,   alarm_en_next;
   logic               alarm_reg,      alarm_next;
   logic               autoreset_reg,  autoreset_next;
   logic               set_go_reg,     set_go_next;
   logic               cap_go_reg,     cap_go_next;
   logic               ar_pend_reg,    ar_pend_next;

   // timer, capture and alarm values
   logic [TIMER_W-1:0] timer_reg,      timer_next;
   logic [TIMER_W-1:0] capture_reg,    capture_next;
   logic [TIMER_W-1:0] alarm_val_reg,  alarm_val_next;

   // interrupt and bus state
   logic [IRQ_W-1:0]   status_reg,     status_next;
   logic [IRQ_W-1:0]   mask_reg,       mask_next;
   logic [31:0]        prdata_reg,     prdata_next;

   // decode strobes and events
   logic               tick;
   logic               timeout;
   logic               wr_acc;
   logic               rd_setup;
   logic               rd_acc;
   logic               mapped;
   logic               fail_evt;
   logic               alarm_evt;
   logic [7:0]         ctrl_view;
   logic               wr_ctl;
   logic               wr_cap;
   logic               wr_alm;
   logic               wr_mask;
   logic               rd_stat;
   logic               alarm_match;

   // oscillator pin conditioning and missing-clock timer
   rcr_clock_watch #(
      .LIMIT (MCD_LIMIT)
   ) u_watch (
      .pclk      (pclk),
      .presetn   (presetn),
      .osc_in    (osc_in),
      .detect_en (mcd_en_reg && osc_en_reg),
      .tick      (tick),
      .timeout   (timeout)
   );

   // bus decode and control view
   always_comb begin
      mapped   = hit(paddr, ADDR_CONTROL) || hit(paddr, ADDR_CAPTURE)
                 || hit(paddr, ADDR_ALARM) || hit(paddr, ADDR_STATUS)
                 || hit(paddr, ADDR_MASK);
      wr_acc   = psel && penable && pwrite && mapped;
      rd_acc   = psel && penable && !pwrite;
      rd_setup = psel && !penable && !pwrite;
      wr_ctl   = wr_acc && hit(paddr, ADDR_CONTROL);
      wr_cap   = wr_acc && hit(paddr, ADDR_CAPTURE);
      wr_alm   = wr_acc && hit(paddr, ADDR_ALARM);
      wr_mask  = wr_acc && hit(paddr, ADDR_MASK);
      rd_stat  = rd_acc && hit(paddr, ADDR_STATUS);
      // compare on the count before this tick's increment
      alarm_match = alarm_en_reg && (timer_reg == alarm_val_reg);

      ctrl_view = RST_BYTE;
      ctrl_view[BIT_OSC_EN]   = osc_en_reg;
      ctrl_view[BIT_MCD_EN]   = mcd_en_reg;
      ctrl_view[BIT_OSC_FAIL] = fail_reg;
      ctrl_view[BIT_RUN]      = run_reg;
      ctrl_view[BIT_ALARM_EN] = alarm_en_reg;
      ctrl_view[BIT_ALARM_AR] = alarm_reg;
      ctrl_view[BIT_SET_GO]   = set_go_reg;
      ctrl_view[BIT_CAP_GO]   = cap_go_reg;
   end

   // control, transfer and timer next state
   always_comb begin
      osc_en_next    = osc_en_reg;
      mcd_en_next    = mcd_en_reg;
      fail_next      = fail_reg;
      run_next       = run_reg;
      alarm_en_next  = alarm_en_reg;
      alarm_next     = alarm_reg;
      autoreset_next = autoreset_reg;
      set_go_next    = set_go_reg;
      cap_go_next    = cap_go_reg;
      ar_pend_next   = ar_pend_reg;
      timer_next     = timer_reg;
      capture_next   = capture_reg;
      alarm_val_next = alarm_val_reg;
      mask_next      = mask_reg;
      fail_evt       = 1'b0;
      alarm_evt      = 1'b0;

      // software side
      if (wr_ctl) begin
         osc_en_next    = pwdata[BIT_OSC_EN];
         mcd_en_next    = pwdata[BIT_MCD_EN];
         run_next       = pwdata[BIT_RUN];
         alarm_en_next  = pwdata[BIT_ALARM_EN];
         autoreset_next = pwdata[BIT_ALARM_AR];
         if (!pwdata[BIT_OSC_FAIL]) begin
            fail_next = 1'b0;
         end
         if (!pwdata[BIT_ALARM_EN]) begin
            alarm_next = 1'b0;
         end
         // a zero leaves a transfer in flight alone
         if (pwdata[BIT_SET_GO]) begin
            set_go_next = 1'b1;
         end
         if (pwdata[BIT_CAP_GO]) begin
            cap_go_next = 1'b1;
         end
      end
      if (wr_cap) begin
         capture_next = pwdata[TIMER_W-1:0];
      end
      if (wr_alm) begin
         alarm_val_next = pwdata[TIMER_W-1:0];
      end
      if (wr_mask) begin
         mask_next = pwdata[IRQ_W-1:0];
      end

      // oscillator side: everything moves once per oscillator cycle
      if (tick) begin
         alarm_next = 1'b0;
         if (ar_pend_reg) begin
            timer_next   = '0;
            ar_pend_next = 1'b0;
         end else if (run_reg) begin
            timer_next = timer_reg + TIMER_W'(TIMER_ONE);
         end
         // flag falls now, so the zeroing lands one cycle later
         if (alarm_reg && autoreset_reg) begin
            ar_pend_next = 1'b1;
         end
         if (alarm_match) begin
            alarm_next = 1'b1;
            alarm_evt  = 1'b1;
         end
         if (set_go_reg) begin
            timer_next   = capture_reg;
            ar_pend_next = 1'b0;
            set_go_next  = 1'b0;
         end
         if (cap_go_reg) begin
            capture_next = timer_reg;
            cap_go_next  = 1'b0;
         end
      end

      // hardware set beats a software clear in the same cycle
      if (timeout && mcd_en_reg) begin
         fail_next = 1'b1;
         fail_evt  = 1'b1;
      end
   end

   // sticky interrupt status, set wins over read clear
   always_comb begin
      status_next = status_reg;
      if (rd_stat) begin
         status_next = '0;
      end
      status_next[IRQ_OSC_FAIL] = status_next[IRQ_OSC_FAIL] | fail_evt;
      status_next[IRQ_ALARM]    = status_next[IRQ_ALARM] | alarm_evt;
   end

   // read data registered in setup so it is stable in access
   always_comb begin
      prdata_next = prdata_reg;
      if (rd_setup) begin
         prdata_next = RST_WORD;
         if (hit(paddr, ADDR_CONTROL)) begin
            prdata_next[7:0] = ctrl_view;
         end else if (hit(paddr, ADDR_CAPTURE)) begin
            prdata_next[TIMER_W-1:0] = capture_reg;
         end else if (hit(paddr, ADDR_ALARM)) begin
            prdata_next[TIMER_W-1:0] = alarm_val_reg;
         end else if (hit(paddr, ADDR_STATUS)) begin
            prdata_next[IRQ_W-1:0] = status_reg;
         end else if (hit(paddr, ADDR_MASK)) begin
            prdata_next[IRQ_W-1:0] = mask_reg;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_en_reg    <= 1'b0;
         mcd_en_reg    <= 1'b0;
         fail_reg      <= 1'b0;
         run_reg       <= 1'b0;
         alarm_en_reg  <= 1'b0;
         alarm_reg     <= 1'b0;
         autoreset_reg <= 1'b0;
         set_go_reg    <= 1'b0;
         cap_go_reg    <= 1'b0;
         ar_pend_reg   <= 1'b0;
      end else begin
         osc_en_reg    <= osc_en_next;
         mcd_en_reg    <= mcd_en_next;
         fail_reg      <= fail_next;
         run_reg       <= run_next;
         alarm_en_reg  <= alarm_en_next;
         alarm_reg     <= alarm_next;
         autoreset_reg <= autoreset_next;
         set_go_reg    <= set_go_next;
         cap_go_reg    <= cap_go_next;
         ar_pend_reg   <= ar_pend_next;
      end
   end

   // timer, capture and alarm values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_reg     <= '0;
         capture_reg   <= '0;
         alarm_val_reg <= '0;
      end else begin
         timer_reg     <= timer_next;
         capture_reg   <= capture_next;
         alarm_val_reg <= alarm_val_next;
      end
   end

   // interrupt and bus state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg    <= '0;
         mask_reg      <= '0;
         prdata_reg    <= RST_WORD;
      end else begin
         status_reg    <= status_next;
         mask_reg      <= mask_next;
         prdata_reg    <= prdata_next;
      end
   end

   // zero wait states; unmapped addresses answer with an error
   assign pready      = 1'b1;
   assign pslverr     = psel && penable && !mapped;

   // outputs from registers; irq ors the masked status bits
   assign prdata      = prdata_reg;
   assign osc_enable  = osc_en_reg;
   assign alarm_event = alarm_reg;
   assign irq         = |(status_reg & mask_reg);
endmodule : rcr_control

//--- test/rcr_osc_model.sv
// oscillator source model driving the rtc oscillator pin
`timescale 1ns/1ps
module rcr_osc_model #(
   parameter real HALF_NS = 31.0
) (
   // from the block
   input  wire logic osc_enable,
   // bench freeze, mimics a dead crystal
   input  wire logic stall,
   // oscillator pin
   output logic      osc_in
);
   initial osc_in = 1'b0;
   // a stopped oscillator holds its level, which is what the detector sees
   always begin
      #(HALF_NS);
      if (osc_enable === 1'b1 && stall !== 1'b1) begin
         osc_in = ~osc_in;
      end
   end
endmodule : rcr_osc_model

//--- test/rcr_control_chk.sv
// port assertions for the rtc control register
`timescale 1ns/1ps
module rcr_control_chk
   import rcr_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // oscillator and events
   input wire logic        osc_in,
   input wire logic        osc_enable,
   input wire logic        alarm_event,
   input wire logic        irq
);
   localparam int FLAG_MAX = 64;
   logic acc;
   logic ctl;
   logic aen_reg;
   logic aen_next;
   assign acc = psel && penable;
   assign ctl = paddr[7:2] == ADDR_CONTROL[7:2];
   always_comb begin
      aen_next = aen_reg;
      if (acc && pwrite && ctl) aen_next = pwdata[BIT_ALARM_EN];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) aen_reg <= 1'b0;
      else aen_reg <= aen_next;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_osc_wr;
      acc && pwrite && ctl |=> osc_enable == $past(pwdata[BIT_OSC_EN]);
   endproperty
   a_osc_wr: assert property (p_osc_wr) else $error("osc enable bad");
   property p_osc_hold;
      $changed(osc_enable) |-> $past(acc && pwrite && ctl);
   endproperty
   a_osc_hold: assert property (p_osc_hold) else $error("osc moved");
   property p_osc_rd;
      acc && !pwrite && ctl |-> prdata[BIT_OSC_EN] == osc_enable;
   endproperty
   a_osc_rd: assert property (p_osc_rd) else $error("osc readback");
   property p_alm_en;
      $rose(alarm_event) |-> $past(aen_reg);
   endproperty
   a_alm_en: assert property (p_alm_en) else $error("alarm when off");
   property p_alm_clr;
      acc && pwrite && ctl && !pwdata[BIT_ALARM_EN] |=> !alarm_event;
   endproperty
   a_alm_clr: assert property (p_alm_clr) else $error("flag kept");
   property p_alm_len;
      $rose(alarm_event) |-> ##[1:FLAG_MAX] !alarm_event;
   endproperty
   a_alm_len: assert property (p_alm_len) else $error("flag stuck");
   property p_map;
      acc && ctl |-> !pslverr && pready;
   endproperty
   a_map: assert property (p_map) else $error("control unmapped");
   property p_sticky;
      irq && !acc |=> irq;
   endproperty
   a_sticky: assert property (p_sticky) else $error("irq dropped");
endmodule : rcr_control_chk

bind rcr_control rcr_control_chk i_rcr_control_chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
   .osc_enable(osc_enable), .alarm_event(alarm_event), .irq(irq));

//--- test/rcr_control_test.sv
// self-checking bench for the rtc control register
`timescale 1ns/1ps
module rcr_control_test;
   import rcr_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, stall, err;
   logic        pready, pslverr, osc_in, osc_enable, alarm_event, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, v;
   int          n_mismatch, samples_checked;
   // short detector limit keeps the run brief
   rcr_control #(.MCD_LIMIT(16)) i_rcr_control (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
      .osc_enable(osc_enable), .alarm_event(alarm_event), .irq(irq));
   rcr_osc_model i_rcr_osc_model (
      .osc_enable(osc_enable), .stall(stall), .osc_in(osc_in));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next setup never re-raises psel in this step
      @(posedge pclk);
   endtask : apb
   task automatic poll(int b);
      for (int i = 0; i < 40; i++) begin
         apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
         if (rd[b] === 1'b0) break;
      end
      chk("go_bit", rd[b], 32'h0000_0000);
   endtask : poll
   task automatic summarize();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   task automatic t_rst();
      apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
      chk("ctl_rst", rd & 32'hFFFF_FFDF, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped", err, 32'h0000_0001);
   endtask : t_rst
   task automatic t_osc();
      apb(1'b1, ADDR_CONTROL, 32'h0000_0084);
      apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
      chk("ctl_osc", rd, 32'h0000_0080);
   endtask : t_osc
   task automatic t_tmr();
      apb(1'b1, ADDR_CAPTURE, 32'h0000_1000);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0082);
      poll(BIT_SET_GO);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0081);
      poll(BIT_CAP_GO);
      apb(1'b0, ADDR_CAPTURE, 32'h0000_0000);
      chk("cap_set", rd, 32'h0000_1000);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0090);
      repeat (100) @(posedge pclk);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0081);
      poll(BIT_CAP_GO);
      apb(1'b0, ADDR_CAPTURE, 32'h0000_0000);
      v = rd;
      chk("ran", rd > 32'h0000_1004, 32'h0000_0001);
      apb(1'b1, ADDR_CAPTURE, 32'h0000_0000);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0080);
      repeat (40) @(posedge pclk);
      apb(1'b0, ADDR_CAPTURE, 32'h0000_0000);
      chk("no_go", rd, 32'h0000_0000);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0081);
      poll(BIT_CAP_GO);
      apb(1'b0, ADDR_CAPTURE, 32'h0000_0000);
      chk("held", rd, v);
   endtask : t_tmr
   task automatic t_alm();
      apb(1'b1, ADDR_MASK, 32'h0000_0002);
      apb(1'b1, ADDR_ALARM, 32'h0000_0008);
      // timer must start from zero, so capture is cleared before the set copies it
      apb(1'b1, ADDR_CAPTURE, 32'h0000_0000);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0082);
      poll(BIT_SET_GO);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0098);
      for (int i = 0; i < 600 && alarm_event !== 1'b1; i++) @(posedge pclk);
      chk("alarm", alarm_event, 32'h0000_0001);
      apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
      chk("flag_rd", rd[BIT_ALARM_AR], 32'h0000_0001);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0090);
      apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
      chk("flag_clr", rd[BIT_ALARM_AR], 32'h0000_0000);
      chk("irq_on", irq, 32'h0000_0001);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk("status", rd, 32'h0000_0002);
      @(posedge pclk);
      chk("irq_off", irq, 32'h0000_0000);
   endtask : t_alm
   task automatic t_ar();
      apb(1'b1, ADDR_CAPTURE, 32'h0000_0000);
      apb(1'b1, ADDR_ALARM, 32'h0000_0003);
      apb(1'b1, ADDR_CONTROL, 32'h0000_009E);
      poll(BIT_SET_GO);
      repeat (400) @(posedge pclk);
      apb(1'b1, ADDR_CONTROL, 32'h0000_009D);
      poll(BIT_CAP_GO);
      apb(1'b0, ADDR_CAPTURE, 32'h0000_0000);
      // wraps at alarm value plus two with auto-reset on
      chk("autoreset", rd < 32'h0000_0006, 32'h0000_0001);
      // park the alarm out of reach before anyone disables it
      apb(1'b1, ADDR_ALARM, 32'hFFFF_FFFF);
   endtask : t_ar
   task automatic t_fail();
      apb(1'b1, ADDR_MASK, 32'h0000_0001);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0080);
      stall <= 1'b1;
      repeat (60) @(posedge pclk);
      apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
      chk("no_fail", rd[BIT_OSC_FAIL], 32'h0000_0000);
      apb(1'b1, ADDR_CONTROL, 32'h0000_00C0);
      repeat (60) @(posedge pclk);
      apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
      chk("fail", rd[BIT_OSC_FAIL], 32'h0000_0001);
      chk("irq_fail", irq, 32'h0000_0001);
      stall <= 1'b0;
      repeat (60) @(posedge pclk);
      apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
      chk("sticky", rd[BIT_OSC_FAIL], 32'h0000_0001);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0080);
      apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
      chk("sw_clr", rd[BIT_OSC_FAIL], 32'h0000_0000);
   endtask : t_fail
   initial begin
      #50000;
      n_mismatch++;
      summarize();
   end
   initial begin
      {presetn, psel, penable, pwrite, stall} = 5'b0_0000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_rst();
      t_osc();
      t_tmr();
      t_alm();
      t_ar();
      t_fail();
      summarize();
   end
endmodule : rcr_control_test
